/* design/dccu_map.vh */
// Register map, field positions, reset values and timing counts of the capture/compare block
`ifndef DCCU_MAP_VH
`define DCCU_MAP_VH
// ==========================================================
// Register offsets (byte addresses)
`define DCCU_CH_VAL_BASE   12'h000
`define DCCU_CH_MODE_BASE  12'h080
`define DCCU_TB_BASE       12'h100
`define DCCU_IC_BASE       12'h200
`define DCCU_STAT_LO       12'h300
`define DCCU_STAT_HI       12'h304
`define DCCU_CLR_LO        12'h308
`define DCCU_CLR_HI        12'h30c
`define DCCU_EN_LO         12'h310
`define DCCU_EN_HI         12'h314
`define DCCU_VAL_MASK      12'hf80
`define DCCU_TB_MASK       12'hfc0
`define DCCU_IC_MASK       12'he00
// ==========================================================
// Sizes
`define DCCU_NCH           32
`define DCCU_NTB           4
`define DCCU_NSRC          36
`define DCCU_NSRC7         7'h24
// ==========================================================
// Channel mode register fields
`define DCCU_MD_BSEL       3
`define DCCU_MD_ERISE      4
`define DCCU_MD_EFALL      5
`define DCCU_MD_DBL        6
`define DCCU_MODE_OFF      3'h0
`define DCCU_MODE_CAP      3'h1
`define DCCU_MODE_CMP0     3'h4
`define DCCU_MODE_CMP1     3'h5
`define DCCU_MODE_CMP2     3'h6
`define DCCU_MODE_CMP3     3'h7
// ==========================================================
// Time base control fields
`define DCCU_TC_SRC_PRE    2'h0
`define DCCU_TC_SRC_GPT    2'h1
`define DCCU_TC_SRC_EXT    2'h2
`define DCCU_TC_RUN        5
`define DCCU_TC_ERISE      6
`define DCCU_TC_EFALL      7
// ==========================================================
// Interrupt control byte fields
`define DCCU_IC_FLAG       7
`define DCCU_IC_EN         6
// ==========================================================
// Reset values and timing
`define DCCU_RST16         16'h0000
`define DCCU_RST8          8'h00
`define DCCU_CNT_MAX       16'hffff
`define DCCU_PRE_MIN       10'h008
`define DCCU_PRE_ONE       10'h001
`endif

/* design/dccu_top.v */
// Dual capture/compare unit: 32 channels, four reloadable time bases, APB registers
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "dccu_map.vh"

// Notes on behaviour
// - Sixteen channels per unit, base and function selectable
// - Each channel owns one pin, input or output
// - Channels 24 to 27 never drive pins
// - Four 16-bit counters with reload registers
// - Count from prescaler or general timer overflow
// - First base per unit accepts external count
// - Prescaler divides by 8 up to 1024
// - Separate external inputs per unit, EXT_A_I and EXT_B_I
// - Capture latches base and raises request
// - Capture on rising, falling or both edges
// - Compare channels checked against base after each count step
// - Mode 0 interrupts every match, pin untouched
// - Mode 1 toggles pin every match
// - Mode 2 one interrupt per timer period
// - Mode 3 sets pin, overflow clears it
// - Double register mode, two matches toggle pin
// - Finest tick is eight CPU clocks
// - Per source control byte: flag, enable, levels
module dccu_top (
	input  wire        CORE_CLK_I,
	input  wire        RESET_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output reg         PREADY_O,
	output reg         PSLVERR_O,
	input  wire [31:0] CC_PIN_I,
	output wire [31:0] CC_PIN_O,
	output wire [31:0] CC_OE_O,
	input  wire        EXT_A_I,
	input  wire        EXT_B_I,
	input  wire        GPT_OVF_I,
	output reg         IRQ_O
);

// ==========================================================
// Bus decode
wire [11:0] addr_w  = {PADDR_I[11:2], 2'h0};
wire        wr_en   = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
wire        in_val  = (addr_w & `DCCU_VAL_MASK) == `DCCU_CH_VAL_BASE;
wire        in_mode = (addr_w & `DCCU_VAL_MASK) == `DCCU_CH_MODE_BASE;
wire        in_tb   = ((addr_w & `DCCU_TB_MASK) == `DCCU_TB_BASE) && (addr_w[3:2] != 2'h3);
wire        in_ic   = ((addr_w & `DCCU_IC_MASK) == `DCCU_IC_BASE) && (addr_w[8:2] < `DCCU_NSRC7);

// ==========================================================
// Shared state
reg  [9:0]  pre_reg;
reg  [35:0] flag_reg;
reg  [35:0] ien_reg;
reg  [5:0]  lvl_reg [0:35];
wire [15:0] val_w   [0:31];
wire [7:0]  mode_w  [0:31];
wire [15:0] cnt_w   [0:3];
wire [15:0] rel_w   [0:3];
wire [7:0]  ctl_w   [0:3];
wire [3:0]  step_w;
wire [3:0]  ovf_w;
wire [31:0] mt_w;
wire [31:0] ch_evt_w;

// ==========================================================
// Prescaler
always @(posedge CORE_CLK_I) begin
	if (RESET_I) begin
		pre_reg <= 10'h000;
	end else begin
		pre_reg <= pre_reg + `DCCU_PRE_ONE;
	end
end

// ==========================================================
// Time bases
genvar t;
generate
	for (t = 0; t < 4; t = t + 1) begin : tb
		localparam [1:0] TI = t;
		reg  [15:0] cnt_reg;
		reg  [15:0] rel_reg;
		reg  [7:0]  ctl_reg;
		reg         step_reg;
		reg         sy1_reg;
		reg         sy2_reg;
		reg         sy3_reg;
		reg         filt_reg;
		wire        ext_pin = (t < 2) ? EXT_A_I : EXT_B_I;
		wire [9:0]  pmask   = (`DCCU_PRE_MIN << ctl_reg[2:0]) - `DCCU_PRE_ONE;
		wire        pre_tk  = (pre_reg & pmask) == pmask;
		wire        agree   = sy2_reg == sy3_reg;
		wire        e_rise  = agree & sy3_reg & ~filt_reg;
		wire        e_fall  = agree & ~sy3_reg & filt_reg;
		wire        ext_tk  = (e_rise & ctl_reg[`DCCU_TC_ERISE]) | (e_fall & ctl_reg[`DCCU_TC_EFALL]);
		reg         tick;
		wire        sel     = wr_en & in_tb & (addr_w[5:4] == TI);
		wire        inc     = ctl_reg[`DCCU_TC_RUN] & tick;
		always @* begin
			case (ctl_reg[4:3])
				`DCCU_TC_SRC_PRE: tick = pre_tk;
				`DCCU_TC_SRC_GPT: tick = GPT_OVF_I;
				`DCCU_TC_SRC_EXT: tick = (t % 2 == 0) ? ext_tk : 1'b0;
				default:          tick = 1'b0;
			endcase
		end
		always @(posedge CORE_CLK_I) begin
			if (RESET_I) begin
				cnt_reg  <= `DCCU_RST16;
				rel_reg  <= `DCCU_RST16;
				ctl_reg  <= `DCCU_RST8;
				step_reg <= 1'b0;
				sy1_reg  <= 1'b0;
				sy2_reg  <= 1'b0;
				sy3_reg  <= 1'b0;
				filt_reg <= 1'b0;
			end else begin
				sy1_reg  <= ext_pin;
				sy2_reg  <= sy1_reg;
				sy3_reg  <= sy2_reg;
				if (agree) begin
					filt_reg <= sy3_reg;
				end
				step_reg <= inc;
				if (sel && addr_w[3:2] == 2'h1) begin
					rel_reg <= PWDATA_I[15:0];
				end
				if (sel && addr_w[3:2] == 2'h2) begin
					ctl_reg <= PWDATA_I[7:0];
				end
				if (sel && addr_w[3:2] == 2'h0) begin
					cnt_reg <= PWDATA_I[15:0];
				end else if (inc && cnt_reg == `DCCU_CNT_MAX) begin
					cnt_reg <= rel_reg;
				end else if (inc) begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end
		assign cnt_w[t]  = cnt_reg;
		assign rel_w[t]  = rel_reg;
		assign ctl_w[t]  = ctl_reg;
		assign step_w[t] = step_reg;
		assign ovf_w[t]  = inc & (cnt_reg == `DCCU_CNT_MAX);
	end
endgenerate

// ==========================================================
// Channels
genvar g;
generate
	for (g = 0; g < 32; g = g + 1) begin : ch
		localparam [4:0] GI   = g;
		localparam       LOW  = (g % 16) < 8;
		localparam       PART = g | 8;
		localparam       INON = (g >= 24) && (g <= 27);
		reg  [15:0] val_reg;
		reg  [7:0]  mode_reg;
		reg         pin_reg;
		reg         oe_reg;
		reg         done_reg;
		reg         sy1_reg;
		reg         sy2_reg;
		reg         sy3_reg;
		reg         filt_reg;
		wire [1:0]  b      = {GI[4], mode_reg[`DCCU_MD_BSEL]};
		wire [2:0]  md     = mode_reg[2:0];
		wire        agree  = sy2_reg == sy3_reg;
		wire        e_rise = agree & sy3_reg & ~filt_reg;
		wire        e_fall = agree & ~sy3_reg & filt_reg;
		wire        cap    = (md == `DCCU_MODE_CAP) &
			((e_rise & mode_reg[`DCCU_MD_ERISE]) | (e_fall & mode_reg[`DCCU_MD_EFALL]));
		wire        mt     = md[2] & step_w[b] & (cnt_w[b] == val_reg);
		wire        once   = (md == `DCCU_MODE_CMP2) | (md == `DCCU_MODE_CMP3);
		wire        cmp_ev = mt & (~once | ~done_reg);
		wire        dbl_tg = LOW & mode_reg[`DCCU_MD_DBL] & mt_w[PART];
		wire        tog    = (mt & (md == `DCCU_MODE_CMP1)) | dbl_tg;
		wire        wv     = wr_en & in_val & (addr_w[6:2] == GI);
		wire        wm     = wr_en & in_mode & (addr_w[6:2] == GI);
		always @(posedge CORE_CLK_I) begin
			if (RESET_I) begin
				val_reg  <= `DCCU_RST16;
				mode_reg <= `DCCU_RST8;
				pin_reg  <= 1'b0;
				oe_reg   <= 1'b0;
				done_reg <= 1'b0;
				sy1_reg  <= 1'b0;
				sy2_reg  <= 1'b0;
				sy3_reg  <= 1'b0;
				filt_reg <= 1'b0;
			end else begin
				sy1_reg <= CC_PIN_I[g];
				sy2_reg <= sy1_reg;
				sy3_reg <= sy2_reg;
				if (agree) begin
					filt_reg <= sy3_reg;
				end
				if (wm) begin
					mode_reg <= PWDATA_I[7:0];
				end
				if (cap) begin
					val_reg <= cnt_w[b];
				end else if (wv) begin
					val_reg <= PWDATA_I[15:0];
				end
				oe_reg <= (md[2] | (LOW & mode_reg[`DCCU_MD_DBL])) & ~INON;
				if (mt && once) begin
					done_reg <= 1'b1;
				end else if (ovf_w[b]) begin
					done_reg <= 1'b0;
				end
				if (tog) begin
					pin_reg <= ~pin_reg;
				end else if (cmp_ev && md == `DCCU_MODE_CMP3) begin
					pin_reg <= 1'b1;
				end else if (ovf_w[b] && md == `DCCU_MODE_CMP3) begin
					pin_reg <= 1'b0;
				end
			end
		end
		assign val_w[g]    = val_reg;
		assign mode_w[g]   = mode_reg;
		assign mt_w[g]     = mt;
		assign ch_evt_w[g] = cap | cmp_ev;
		assign CC_PIN_O[g] = INON ? 1'b0 : pin_reg;
		assign CC_OE_O[g]  = oe_reg;
	end
endgenerate

// ==========================================================
// Interrupt flags, enables and levels
wire [35:0] evt_w   = {ovf_w, ch_evt_w};
wire [6:0]  src_w   = addr_w[8:2];
wire        ic_wr   = wr_en & in_ic;
wire [35:0] clr_w   = {(wr_en && addr_w == `DCCU_CLR_HI) ? PWDATA_I[3:0] : 4'h0,
	(wr_en && addr_w == `DCCU_CLR_LO) ? PWDATA_I : 32'h0000_0000};
integer s;
always @(posedge CORE_CLK_I) begin
	if (RESET_I) begin
		flag_reg <= 36'h0_0000_0000;
		ien_reg  <= 36'h0_0000_0000;
		IRQ_O    <= 1'b0;
		for (s = 0; s < 36; s = s + 1) begin
			lvl_reg[s] <= 6'h00;
		end
	end else begin
		IRQ_O <= |(flag_reg & ien_reg);
		if (wr_en && addr_w == `DCCU_EN_LO) begin
			ien_reg[31:0] <= PWDATA_I;
		end
		if (wr_en && addr_w == `DCCU_EN_HI) begin
			ien_reg[35:32] <= PWDATA_I[3:0];
		end
		for (s = 0; s < 36; s = s + 1) begin
			if (evt_w[s]) begin
				flag_reg[s] <= 1'b1;
			end else if (ic_wr && src_w == s) begin
				flag_reg[s] <= PWDATA_I[`DCCU_IC_FLAG];
			end else if (clr_w[s]) begin
				flag_reg[s] <= 1'b0;
			end
			if (ic_wr && src_w == s) begin
				ien_reg[s] <= PWDATA_I[`DCCU_IC_EN];
				lvl_reg[s] <= PWDATA_I[5:0];
			end
		end
	end
end

// ==========================================================
// Read mux and APB answer
reg [31:0] rdata_next;
reg        err_next;
always @* begin
	rdata_next = 32'h0000_0000;
	err_next   = 1'b0;
	if (in_val) begin
		rdata_next = {16'h0000, val_w[addr_w[6:2]]};
	end else if (in_mode) begin
		rdata_next = {24'h00_0000, mode_w[addr_w[6:2]]};
	end else if (in_tb) begin
		case (addr_w[3:2])
			2'h0:    rdata_next = {16'h0000, cnt_w[addr_w[5:4]]};
			2'h1:    rdata_next = {16'h0000, rel_w[addr_w[5:4]]};
			default: rdata_next = {24'h00_0000, ctl_w[addr_w[5:4]]};
		endcase
	end else if (in_ic) begin
		rdata_next = {24'h00_0000, flag_reg[src_w[5:0]], ien_reg[src_w[5:0]], lvl_reg[src_w[5:0]]};
	end else if (addr_w == `DCCU_STAT_LO) begin
		rdata_next = flag_reg[31:0];
	end else if (addr_w == `DCCU_STAT_HI) begin
		rdata_next = {28'h000_0000, flag_reg[35:32]};
	end else if (addr_w == `DCCU_EN_LO) begin
		rdata_next = ien_reg[31:0];
	end else if (addr_w == `DCCU_EN_HI) begin
		rdata_next = {28'h000_0000, ien_reg[35:32]};
	end else if (addr_w == `DCCU_CLR_LO || addr_w == `DCCU_CLR_HI) begin
		rdata_next = 32'h0000_0000;
	end else begin
		err_next = 1'b1;
	end
end

always @(posedge CORE_CLK_I) begin
	if (RESET_I) begin
		PREADY_O  <= 1'b0;
		PRDATA_O  <= 32'h0000_0000;
		PSLVERR_O <= 1'b0;
	end else begin
		PREADY_O  <= PSEL_I & PENABLE_I & ~PREADY_O;
		PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & err_next;
		if (PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I) begin
			PRDATA_O <= rdata_next;
		end else begin
			PRDATA_O <= 32'h0000_0000;
		end
	end
end

endmodule // dccu_top

/* verif/dccu_checker.sv */
// Port checker for the capture/compare block
`timescale 1ns/1ps
module dccu_checker (
	input wire        CORE_CLK_I,
	input wire        RESET_I,
	input wire        PSEL_I,
	input wire        PENABLE_I,
	input wire        PWRITE_I,
	input wire [31:0] PRDATA_O,
	input wire        PREADY_O,
	input wire        PSLVERR_O,
	input wire [31:0] CC_PIN_O,
	input wire [31:0] CC_OE_O,
	input wire        IRQ_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);
	// ==========================================================
	// Assertions
	chk_input_only_quiet: assert property ((CC_OE_O[27:24] | CC_PIN_O[27:24]) == 4'h0)
		else $error("Input-only channel drives its pin");
	chk_ready_due: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
		else $error("Access phase not answered after one wait state");
	chk_ready_once: assert property (PREADY_O |=> !PREADY_O)
		else $error("Ready held longer than one cycle");
	chk_ready_cause: assert property ($rose(PREADY_O) |-> $past(PSEL_I && PENABLE_I))
		else $error("Ready without an access phase");
	chk_err_clean: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
		else $error("Error response malformed");
	chk_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("Read data outside a response");
	chk_irq_sticky: assert property (IRQ_O && !(PREADY_O && PWRITE_I) && !$past(PREADY_O && PWRITE_I) |=> IRQ_O)
		else $error("Interrupt dropped without a write");
	chk_reset_clean: assert property ($fell(RESET_I) |-> (CC_OE_O | CC_PIN_O) == 32'h0 && !IRQ_O)
		else $error("Outputs not cleared by reset");
endmodule // dccu_checker

bind dccu_top dccu_checker u_dccu_checker (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CC_PIN_O(CC_PIN_O), .CC_OE_O(CC_OE_O),
	.IRQ_O(IRQ_O));

/* verif/dccu_pins.sv */
// Pin side model: channel pin levels and the shared count input
`timescale 1ns/1ps
module dccu_pins (
	input  wire        clk_i,
	input  wire [31:0] pin_o_i,
	input  wire [31:0] oe_i,
	output wire [31:0] pin_i_o,
	output reg         ext_o
);
	reg [31:0] lvl_reg;
	// A driven pin shows the block's level, an idle one the model's
	assign pin_i_o = (pin_o_i & oe_i) | (lvl_reg & ~oe_i);
	initial begin
		lvl_reg = 32'h0;
		ext_o = 1'b0;
	end
	task set_pin(input int ch, input logic v);
		@(posedge clk_i);
		lvl_reg[ch] <= v;
		repeat (8) @(posedge clk_i);
	endtask
	// One signal feeds both first bases
	task pulse_ext(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			ext_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask
endmodule // dccu_pins

/* verif/tb_top.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst, psel, pen, pwr, gpt, rdy, err, irq, ext, e;
	logic [11:0] addr;
	logic [31:0] wdat, rdat, rq, pin_i, pin_o, oe;
	int          miscompares = 0, n_compared = 0, c;
	dccu_top u_dccu_top (.CORE_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(rdat), .PREADY_O(rdy),
		.PSLVERR_O(err), .CC_PIN_I(pin_i), .CC_PIN_O(pin_o), .CC_OE_O(oe),
		.EXT_A_I(ext), .EXT_B_I(ext), .GPT_OVF_I(gpt), .IRQ_O(irq));
	dccu_pins u_dccu_pins (.clk_i(clk), .pin_o_i(pin_o), .oe_i(oe), .pin_i_o(pin_i),
		.ext_o(ext));
	// ==========================================================
	// Shared tasks
	task conclude;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task hang;
		miscompares++;
		$display("BAD %0t wait ran out", $time);
		conclude();
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge clk);
			psel <= 1'b1;
			pwr <= w;
			addr <= a;
			wdat <= d;
			@(posedge clk);
			pen <= 1'b1;
			do begin
				@(posedge clk);
				n++;
			end while (rdy !== 1'b1 && n < 20);
			rq = rdat;
			e = err;
			psel <= 1'b0;
			pen <= 1'b0;
			if (n >= 20) hang();
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rq, x);
	endtask
	task wait_pin(input int b);
		logic s;
		begin
			s = pin_o[b];
			c = 0;
			while (pin_o[b] === s && c < 20000) begin
				@(posedge clk);
				c++;
			end
			if (c >= 20000) hang();
		end
	endtask
	task gpt_n(input int n);
		repeat (n) begin
			@(posedge clk);
			gpt <= 1'b1;
			@(posedge clk);
			gpt <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask
	// ==========================================================
	// Scenarios
	task t_regs;
		rd(12'h080, 32'h0);
		wr(12'h200, 32'hffffffff);
		rd(12'h200, 32'hff);
		apb(1'b0, 12'h10c, 32'h0);
		chk({31'h0, e}, 32'h1);
		wr(12'h200, 32'h0);
		$display("regs done");
	endtask
	task t_tick;
		wr(12'h100, 32'hfffd);
		wr(12'h104, 32'hfff0);
		wr(12'h000, 32'hfffe);
		wr(12'h080, 32'h05);
		for (int s = 0; s < 8; s++) begin
			wr(12'h108, 32'h20 | s);
			wait_pin(0);
			wait_pin(0);
			chk(c, 128 << s);
		end
		rd(12'h304, 32'h1);
		chk(oe, 32'h1);
		$display("tick done");
	endtask
	task t_cap;
		wr(12'h108, 32'h38);
		wr(12'h100, 32'h1234);
		wr(12'h308, 32'hffffffff);
		wr(12'h310, 32'h8);
		wr(12'h08c, 32'h11);
		u_dccu_pins.set_pin(3, 1'b1);
		chk({31'h0, irq}, 32'h1);
		rd(12'h00c, 32'h1234);
		wr(12'h310, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(12'h308, 32'h8);
		u_dccu_pins.set_pin(3, 1'b0);
		rd(12'h300, 32'h0);
		wr(12'h08c, 32'h21);
		u_dccu_pins.set_pin(3, 1'b1);
		u_dccu_pins.set_pin(3, 1'b0);
		rd(12'h300, 32'h8);
		$display("capture done");
	endtask
	task t_cmp;
		wr(12'h118, 32'h28);
		wr(12'h110, 32'hfff0);
		wr(12'h114, 32'hfff0);
		for (int k = 1; k < 5; k++) begin
			wr(12'h000 + 4 * k, 32'hfff2);
		end
		wr(12'h00c, 32'hfff1);
		wr(12'h02c, 32'hfff4);
		wr(12'h084, 32'h0f);
		wr(12'h088, 32'h0c);
		wr(12'h08c, 32'h4d);
		wr(12'h090, 32'h0e);
		wr(12'h0ac, 32'h0c);
		wr(12'h0e0, 32'h05);
		wr(12'h308, 32'hffffffff);
		gpt_n(3);
		chk(pin_o & 32'h1e, 32'h0a);
		chk(oe & 32'h0f00001e, 32'h1e);
		rd(12'h300, 32'h1e);
		wr(12'h308, 32'hffffffff);
		wr(12'h008, 32'hfff5);
		wr(12'h010, 32'hfff5);
		gpt_n(3);
		rd(12'h300, 32'h804);
		chk(pin_o & 32'h1e, 32'h02);
		gpt_n(10);
		chk(pin_o & 32'h1e, 32'h0);
		rd(12'h304, 32'h3);
		$display("compare done");
	endtask
	task t_ext;
		wr(12'h108, 32'h70);
		wr(12'h128, 32'h70);
		wr(12'h100, 32'h0);
		wr(12'h120, 32'h0);
		u_dccu_pins.pulse_ext(5);
		rd(12'h100, 32'h5);
		rd(12'h120, 32'h5);
		$display("external done");
	endtask
	// ==========================================================
	// Clock and main sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{psel, pen, pwr, gpt} = 4'h0;
		addr = 12'h0;
		wdat = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_tick();
		t_cap();
		t_cmp();
		t_ext();
		conclude();
	end
endmodule // tb_top
